/* core/spi_core_pkg.sv */
/*
 Shared constants of the byte-oriented SPI core: data, counter and width
 field sizes, queue depth and reset values.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package spi_core_pkg;
   // -----------------------------------------------------------------
   // sizes
   // -----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int COUNT_W = 11;
   localparam int WIDTH_W = 3;
   localparam int BITCNT_W = 3;
   localparam int QUEUE_DEPTH = 2;

   // -----------------------------------------------------------------
   // field codes and reset values
   // -----------------------------------------------------------------
   localparam logic [WIDTH_W-1:0] WIDTH_FULL_BYTE = 3'h0;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 11'h000;
   localparam logic [BITCNT_W-1:0] BITCNT_RESET = 3'h0;
   localparam logic DIR_OUTPUT = 1'b0;
   localparam logic SCK_IDLE = 1'b0;
   localparam logic SS_IDLE = 1'b1;
endpackage : spi_core_pkg

/* core/queue_if.sv */
/*
 Interface joining the core to one of its byte queues.
 Assumes both ends run on the core clock.
*/
`timescale 1ns/1ns
interface queue_if #(parameter int W = 8);
   logic push;
   logic [W-1:0] pushData;
   logic pop;
   logic [W-1:0] popData;
   logic clear;
   logic full;
   logic empty;
   modport owner(output push, output pushData, output pop, output clear,
                 input popData, input full, input empty);
   modport store(input push, input pushData, input pop, input clear,
                 output popData, output full, output empty);
endinterface : queue_if

/* core/spi_byte_queue.sv */
/*
 Show-ahead byte queue with parameter depth and an occupancy clear.
 Assumes a synchronous active-low reset already released cleanly.
*/
`timescale 1ns/1ns
module spi_byte_queue #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic clock,
   input wire logic rstSync_n,
   queue_if.store q
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULLCNT = CW'(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic [CW-1:0] occupancy, next_occupancy;
   logic doPush, doPop;

   assign q.full = (occupancy == FULLCNT);
   assign q.empty = (occupancy == '0);
   assign q.popData = mem[rdPtr];
   // a write into a full queue leaves the stored words alone
   assign doPush = q.push && !q.full && !q.clear;
   assign doPop = q.pop && !q.empty && !q.clear;

   always_comb begin
      next_wrPtr = wrPtr;
      next_rdPtr = rdPtr;
      next_occupancy = occupancy;
      if (q.clear) begin
         next_wrPtr = '0;
         next_rdPtr = '0;
         next_occupancy = '0;
      end else begin
         if (doPush) begin
            next_wrPtr = (wrPtr == LAST) ? '0 : PW'(wrPtr + 1'b1);
         end
         if (doPop) begin
            next_rdPtr = (rdPtr == LAST) ? '0 : PW'(rdPtr + 1'b1);
         end
         if (doPush && !doPop) begin
            next_occupancy = CW'(occupancy + 1'b1);
         end else if (doPop && !doPush) begin
            next_occupancy = CW'(occupancy - 1'b1);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstSync_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         occupancy <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         occupancy <= next_occupancy;
      end
   end

   always_ff @(posedge clock) begin
      if (doPush) begin
         mem[wrPtr] <= q.pushData;
      end
   end
endmodule : spi_byte_queue

/* core/spi_enable_busy_fifo_core.sv */
/*
 Top of the SPI core: enable, busy flag, transmit and receive queues,
 error flags, and a slave-style shifter on the link clock.
 Assumes software-side strobes are one-cycle pulses on the core clock and
 that the link clock only runs while the select line is low.
*/
`timescale 1ns/1ns
// Contract
// - enable activates every SPI input and output; clearing it releases them.
// - clearing enable aborts transfers, stops flag setting, empties both queues; a read while disabled still sets the read error.
// - busy flag stays high for the whole of a transfer in progress; here busy is high only while the remaining transfer count is nonzero.
// - separate transmit and receive queues between software and the shifter.
// - clear-buffers strobe empties both queues.
// - receive port is read-only; each read returns the oldest word and pops it.
// - empty receive read returns zero and sets sticky read error until cleared.
// - receive-full flag is set whenever the receive queue is full.
// - transmit port is write-only; each write appends a word to the queue.
// - write into a full transmit queue keeps data and sets write error.
// - transmit-empty flag is set whenever the transmit queue holds nothing.
// - queue occupancy counts stay internal and are never exposed.
// - with data-out direction cleared the core drives that pin whenever enabled.
// - bit-order control picks most significant first by default, else least.
// - width field gives 1 to 7 bits per transfer, code zero meaning 8.
module spi_enable_busy_fifo_core #(
   parameter int DEPTH = spi_core_pkg::QUEUE_DEPTH
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic lowBitFirst,
   input wire logic [spi_core_pkg::WIDTH_W-1:0] transferWidth,
   input wire logic [spi_core_pkg::COUNT_W-1:0] transferCount,
   input wire logic countLoad,
   input wire logic clearBuffers,
   input wire logic clearReadError,
   input wire logic clearWriteError,
   input wire logic clearCounterZero,
   input wire logic txWrite,
   input wire logic [spi_core_pkg::DATA_W-1:0] txData,
   input wire logic rxRead,
   input wire logic sdoPinDirection,
   input wire logic sckPinDirection,
   input wire logic ssPinDirection,
   input wire logic linkClock,
   input wire logic sdi,
   input wire logic ssIn,
   output logic [spi_core_pkg::DATA_W-1:0] rxData,
   output logic busy,
   output logic counterZeroFlag,
   output logic receiveReadError,
   output logic receiveBufferFull,
   output logic transmitWriteError,
   output logic transmitBufferEmpty,
   output logic sdo,
   output logic sdoOe,
   output logic sckOut,
   output logic sckOe,
   output logic ssOut,
   output logic ssOe
);
   localparam int DW = spi_core_pkg::DATA_W;
   localparam int CW = spi_core_pkg::COUNT_W;
   localparam int BW = spi_core_pkg::BITCNT_W;

   function automatic logic [BW:0] widthBits(input logic [spi_core_pkg::WIDTH_W-1:0] code);
      widthBits = (code == spi_core_pkg::WIDTH_FULL_BYTE) ? 4'h8 : {1'b0, code};
   endfunction : widthBits

   // -----------------------------------------------------------------
   // reset release and queues
   // -----------------------------------------------------------------
   logic [1:0] rstPipe;
   logic rstSync_n;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe <= 2'h0;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstSync_n = rstPipe[1];

   queue_if #(.W(DW)) txQ ();
   queue_if #(.W(DW)) rxQ ();
   spi_byte_queue #(.W(DW), .DEPTH(DEPTH)) txStore (.clock(clock), .rstSync_n(rstSync_n),
      .q(txQ));
   // occupancy stays inside the queues; only the full and empty flags leave them
   spi_byte_queue #(.W(DW), .DEPTH(DEPTH)) rxStore (.clock(clock), .rstSync_n(rstSync_n),
      .q(rxQ));

   // -----------------------------------------------------------------
   // core-side state
   // -----------------------------------------------------------------
   logic enableReg;
   logic txReq, next_txReq;
   logic [DW-1:0] txHoldData, next_txHoldData;
   logic [spi_core_pkg::WIDTH_W-1:0] txHoldWidth, next_txHoldWidth;
   logic txHoldLsb, next_txHoldLsb;
   logic [1:0] ackPipe, rxPipe, ssPipe;
   logic ackSeen, rxSeen;
   logic [CW-1:0] remaining, next_remaining, toIssue, next_toIssue;
   logic [DW-1:0] next_rxData;
   logic next_readErr, next_writeErr, next_zeroFlag;
   logic txPending, txPop, rxEvent;
   // link-side registers read by the core only after a toggle has crossed
   logic ackTog, rxTog;
   logic [DW-1:0] rxWord;

   assign txPending = (txReq != ackSeen);
   assign rxEvent = (rxPipe[1] != rxSeen);
   // at most one word in flight keeps the hold register stable across the crossing;
   // no hand-off while a frame is open, so txReq stands still for the shifter
   assign txPop = enableReg && !txPending && !txQ.empty && (toIssue != '0) && ssPipe[1];

   // disabling or the clear strobe resets both occupancies
   assign txQ.clear = clearBuffers || !enableReg;
   assign rxQ.clear = clearBuffers || !enableReg;
   assign txQ.push = txWrite && enableReg;
   assign txQ.pushData = txData;
   assign txQ.pop = txPop;
   assign rxQ.push = rxEvent && enableReg;
   assign rxQ.pushData = rxWord;
   assign rxQ.pop = rxRead;

   always_comb begin
      next_txReq = txReq;
      next_txHoldData = txHoldData;
      next_txHoldWidth = txHoldWidth;
      next_txHoldLsb = txHoldLsb;
      next_remaining = remaining;
      next_toIssue = toIssue;
      next_rxData = rxData;
      next_readErr = receiveReadError;
      next_writeErr = transmitWriteError;
      next_zeroFlag = counterZeroFlag;
      if (txPop) begin
         next_txHoldData = txQ.popData;
         next_txHoldWidth = transferWidth;
         next_txHoldLsb = lowBitFirst;
         next_txReq = !txReq;
         next_toIssue = CW'(toIssue - 1'b1);
      end
      if (!enableReg) begin
         next_remaining = '0;
         next_toIssue = '0;
         // the link toggles restart from zero, so the request does as well
         next_txReq = 1'b0;
      end else if (countLoad) begin
         next_remaining = transferCount;
         next_toIssue = transferCount;
      end else if (rxEvent && remaining != '0) begin
         next_remaining = CW'(remaining - 1'b1);
      end
      if (rxRead) begin
         next_rxData = rxQ.empty ? spi_core_pkg::DATA_RESET : rxQ.popData;
      end
      // set wins over clear on every sticky flag
      if (clearReadError) begin
         next_readErr = 1'b0;
      end
      if (rxRead && rxQ.empty) begin
         next_readErr = 1'b1;
      end
      if (clearWriteError) begin
         next_writeErr = 1'b0;
      end
      if (txWrite && txQ.full) begin
         next_writeErr = 1'b1;
      end
      if (clearCounterZero) begin
         next_zeroFlag = 1'b0;
      end
      if (enableReg && rxEvent && remaining == CW'(1)) begin
         next_zeroFlag = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstSync_n) begin
         enableReg <= 1'b0;
         txReq <= 1'b0;
         txHoldData <= spi_core_pkg::DATA_RESET;
         txHoldWidth <= spi_core_pkg::WIDTH_FULL_BYTE;
         txHoldLsb <= 1'b0;
         ackPipe <= 2'h0;
         ackSeen <= 1'b0;
         rxPipe <= 2'h0;
         rxSeen <= 1'b0;
         ssPipe <= 2'h3;
         remaining <= spi_core_pkg::COUNT_RESET;
         toIssue <= spi_core_pkg::COUNT_RESET;
         rxData <= spi_core_pkg::DATA_RESET;
         receiveReadError <= 1'b0;
         transmitWriteError <= 1'b0;
         counterZeroFlag <= 1'b0;
         busy <= 1'b0;
         receiveBufferFull <= 1'b0;
         transmitBufferEmpty <= 1'b1;
         sdoOe <= 1'b0;
         sckOut <= spi_core_pkg::SCK_IDLE;
         sckOe <= 1'b0;
         ssOut <= spi_core_pkg::SS_IDLE;
         ssOe <= 1'b0;
      end else begin
         enableReg <= enable;
         txReq <= next_txReq;
         txHoldData <= next_txHoldData;
         txHoldWidth <= next_txHoldWidth;
         txHoldLsb <= next_txHoldLsb;
         // toggles back from the link pass two flops before use, the acknowledge a third one as ackSeen
         // held at the link's reset level while disabled: no stale toggle after enable
         ackPipe <= enableReg ? {ackPipe[0], ackTog} : 2'h0;
         ackSeen <= enableReg ? ackPipe[1] : 1'b0;
         rxPipe <= enableReg ? {rxPipe[0], rxTog} : 2'h0;
         rxSeen <= enableReg ? rxPipe[1] : 1'b0;
         ssPipe <= {ssPipe[0], ssIn};
         remaining <= next_remaining;
         toIssue <= next_toIssue;
         rxData <= next_rxData;
         receiveReadError <= next_readErr;
         transmitWriteError <= next_writeErr;
         counterZeroFlag <= next_zeroFlag;
         busy <= (next_remaining != '0);
         receiveBufferFull <= rxQ.full;
         transmitBufferEmpty <= txQ.empty;
         // while enabled, data-out drives always when its direction is output, else only in a frame
         sdoOe <= enableReg
            && ((sdoPinDirection == spi_core_pkg::DIR_OUTPUT) || !ssPipe[1]);
         sckOut <= spi_core_pkg::SCK_IDLE;
         sckOe <= enableReg && (sckPinDirection == spi_core_pkg::DIR_OUTPUT);
         ssOut <= spi_core_pkg::SS_IDLE;
         ssOe <= enableReg && (ssPinDirection == spi_core_pkg::DIR_OUTPUT);
      end
   end

   // -----------------------------------------------------------------
   // link-side shifter
   // -----------------------------------------------------------------
   // handshake state survives frames; bit state dies with the frame's select
   logic linkArst_n, frameArst_n;
   logic [BW-1:0] bitCnt, next_bitCnt;
   logic [DW-1:0] outWord, next_outWord, inWord, next_inWord, next_rxWord;
   logic [spi_core_pkg::WIDTH_W-1:0] linkWidth, next_linkWidth;
   logic linkLsb, next_linkLsb, next_sdo, next_ackTog, next_rxTog;

   assign linkArst_n = enableReg;
   assign frameArst_n = enableReg && !ssIn;

   always_comb begin
      logic [BW:0] w;
      logic [BW-1:0] idx;
      logic take;
      w = '0;
      idx = '0;
      take = 1'b0;
      next_outWord = outWord;
      next_linkWidth = linkWidth;
      next_linkLsb = linkLsb;
      next_ackTog = ackTog;
      if (bitCnt == '0) begin
         // link clock stands still between frames, so a synchroniser here would go
         // stale; txReq is frozen during frames and the master must leave half a link
         // period between select and the first edge
         take = (txReq != ackTog);
         next_outWord = take ? txHoldData : spi_core_pkg::DATA_RESET;
         next_linkWidth = take ? txHoldWidth : linkWidth;
         next_linkLsb = take ? txHoldLsb : linkLsb;
         next_ackTog = take ? !ackTog : ackTog;
      end
      w = widthBits(next_linkWidth);
      idx = next_linkLsb ? bitCnt : BW'(w - 1'b1 - {1'b0, bitCnt});
      next_sdo = next_outWord[idx];
      next_inWord = (bitCnt == '0) ? spi_core_pkg::DATA_RESET : inWord;
      next_inWord[idx] = sdi;
      next_rxWord = rxWord;
      next_rxTog = rxTog;
      next_bitCnt = BW'(bitCnt + 1'b1);
      if ({1'b0, bitCnt} == BW'(w - 1'b1)) begin
         next_rxWord = next_inWord;
         next_rxTog = !rxTog;
         next_bitCnt = '0;
      end
   end

   always_ff @(posedge linkClock or negedge linkArst_n) begin
      if (!linkArst_n) begin
         ackTog <= 1'b0;
         rxTog <= 1'b0;
         rxWord <= spi_core_pkg::DATA_RESET;
         outWord <= spi_core_pkg::DATA_RESET;
         linkWidth <= spi_core_pkg::WIDTH_FULL_BYTE;
         linkLsb <= 1'b0;
         sdo <= 1'b0;
      end else begin
         // shift state only moves while a frame is open
         if (!ssIn) begin
            ackTog <= next_ackTog;
            rxTog <= next_rxTog;
            rxWord <= next_rxWord;
            outWord <= next_outWord;
            linkWidth <= next_linkWidth;
            linkLsb <= next_linkLsb;
            sdo <= next_sdo;
         end
      end
   end

   always_ff @(posedge linkClock or negedge frameArst_n) begin
      if (!frameArst_n) begin
         bitCnt <= spi_core_pkg::BITCNT_RESET;
         inWord <= spi_core_pkg::DATA_RESET;
      end else begin
         bitCnt <= next_bitCnt;
         inWord <= next_inWord;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstSync_n);

   sequence popToReq;
      txPop ##1 (txReq != $past(txReq));
   endsequence
   empty_read_error_a: assert property (rxRead && rxQ.empty |=> receiveReadError && rxData == '0)
      else $error("empty read did not flag");
   read_error_sticky_a: assert property (receiveReadError && !clearReadError |=> receiveReadError)
      else $error("read error dropped");
   read_pops_oldest_a: assert property (rxRead && !rxQ.empty |=> rxData == $past(rxQ.popData))
      else $error("read returned wrong word");
   full_write_error_a: assert property (txWrite && txQ.full |=> transmitWriteError)
      else $error("full write not flagged");
   status_flags_a: assert property (##1 transmitBufferEmpty == $past(txQ.empty)
      && receiveBufferFull == $past(rxQ.full))
      else $error("queue status flags wrong");
   disable_empties_a: assert property (!enableReg |=> txQ.empty && rxQ.empty && !busy)
      else $error("disable left state behind");
   clear_buffers_a: assert property (clearBuffers |=> txQ.empty && rxQ.empty)
      else $error("clear did not empty queues");
   busy_on_load_a: assert property (enableReg && countLoad && transferCount != '0 |=> busy)
      else $error("busy not raised");
   busy_end_a: assert property (enableReg && !countLoad && rxEvent && remaining == CW'(1)
      |=> !busy && counterZeroFlag)
      else $error("busy did not end on last transfer");
   tx_handoff_a: assert property (txPop |-> popToReq)
      else $error("popped word not handed to link");
   pin_enables_a: assert property (##1 sckOe == ($past(enableReg) && !$past(sckPinDirection))
      && ssOe == ($past(enableReg) && !$past(ssPinDirection)))
      else $error("pin enables wrong");
   sdo_drive_a: assert property (enableReg && !sdoPinDirection |=> sdoOe)
      else $error("data out not driven");
endmodule : spi_enable_busy_fifo_core

/* test/spi_link_master_model.sv */
/*
 Behavioural link master that faces the core's slave shifter.
 Assumes the core samples sdi and updates sdo on the rising link edge.
*/
`timescale 1ns/1ns
module spi_link_master_model #(
   parameter int HALF_NS = 80
) (
   output logic linkClock,
   output logic ssIn,
   output logic sdi,
   input wire logic sdo
);
   initial begin
      linkClock = 1'h0;
      ssIn = 1'h1;
      sdi = 1'h0;
   end

   // -----------------------------------------------------------------
   // one frame; the link clock stands still outside it
   // -----------------------------------------------------------------
   task automatic frame(input logic [7:0] mosi, input int nBits, input logic lsbFirst,
                        output logic [7:0] miso);
      int idx;
      miso = 8'h00;
      #3;
      ssIn = 1'h0;
      for (int i = 0; i < nBits; i++) begin
         idx = lsbFirst ? i : nBits - 1 - i;
         sdi = mosi[idx];
         #HALF_NS linkClock = 1'h1;
         #HALF_NS linkClock = 1'h0;
         miso[idx] = sdo; // sampled on the falling edge
      end
      #HALF_NS ssIn = 1'h1;
      sdi = ~sdi; // released line must not show a stale bit
   endtask : frame
endmodule : spi_link_master_model

/* test/spi_enable_busy_fifo_core_tb.sv */
/*
 Self-checking bench of the SPI core: strobes, queues, flags, link frames.
 Assumes the link master model and the core package.
*/
`timescale 1ns/1ns
module spi_enable_busy_fifo_core_tb;
   localparam int LIMIT = 20000;
   localparam logic [6:0] LOAD = 7'h01, CLRBUF = 7'h02, CLRRE = 7'h04, CLRWE = 7'h08;
   localparam logic [6:0] CLRCZ = 7'h10, WR = 7'h20, RD = 7'h40;
   logic clock, rst_n, enable, lowBitFirst, sdoPinDirection, sckPinDirection, ssPinDirection;
   logic [spi_core_pkg::WIDTH_W-1:0] transferWidth;
   logic [spi_core_pkg::COUNT_W-1:0] transferCount;
   logic [7:0] txData, rxData, miso, m, w8;
   logic [6:0] strb;
   logic linkClock, ssIn, sdi, sdo, busy, counterZeroFlag, receiveReadError, receiveBufferFull;
   logic transmitWriteError, transmitBufferEmpty, sdoOe, sckOut, sckOe, ssOut, ssOe;
   int mismatches = 0, checked = 0, cycles = 0, n;

   spi_enable_busy_fifo_core #(.DEPTH(2)) i_dut (.clock(clock), .rst_n(rst_n),
      .enable(enable), .lowBitFirst(lowBitFirst), .transferWidth(transferWidth),
      .transferCount(transferCount), .countLoad(strb[0]), .clearBuffers(strb[1]),
      .clearReadError(strb[2]), .clearWriteError(strb[3]), .clearCounterZero(strb[4]),
      .txWrite(strb[5]), .txData(txData), .rxRead(strb[6]),
      .sdoPinDirection(sdoPinDirection), .sckPinDirection(sckPinDirection),
      .ssPinDirection(ssPinDirection), .linkClock(linkClock), .sdi(sdi), .ssIn(ssIn),
      .rxData(rxData), .busy(busy), .counterZeroFlag(counterZeroFlag),
      .receiveReadError(receiveReadError), .receiveBufferFull(receiveBufferFull),
      .transmitWriteError(transmitWriteError), .transmitBufferEmpty(transmitBufferEmpty),
      .sdo(sdo), .sdoOe(sdoOe), .sckOut(sckOut), .sckOe(sckOe), .ssOut(ssOut), .ssOe(ssOe));

   spi_link_master_model i_master (.linkClock(linkClock), .ssIn(ssIn), .sdi(sdi), .sdo(sdo));

   always #4 clock = ~clock;

   // -----------------------------------------------------------------
   // access tasks
   // -----------------------------------------------------------------
   task automatic pulse(input logic [6:0] s, input logic [7:0] d = 8'h00);
      @(negedge clock) begin
         strb = s;
         txData = d;
      end
      @(negedge clock) strb = 7'h00;
   endtask : pulse

   task automatic idle(input int k);
      repeat (k) @(negedge clock);
   endtask : idle

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic flag(input logic f, input logic e);
      check({7'h00, f}, {7'h00, e});
   endtask : flag

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   // a hang is cut short here
   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         $display("[ERR] %0t: timeout", $time);
         report_and_stop();
      end
   end

   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial begin
      clock = 1'h0;
      rst_n = 1'h0;
      enable = 1'h0;
      lowBitFirst = 1'h0;
      transferWidth = spi_core_pkg::WIDTH_FULL_BYTE;
      transferCount = 11'h000;
      txData = 8'h00;
      strb = 7'h00;
      sdoPinDirection = 1'h1;
      sckPinDirection = spi_core_pkg::DIR_OUTPUT;
      ssPinDirection = spi_core_pkg::DIR_OUTPUT;
      idle(4);
      rst_n = 1'h1;
      idle(4);
      flag(transmitBufferEmpty, 1'h1);
      flag(sckOe, 1'h0);
      flag(ssOe, 1'h0);
      flag(ssOut, spi_core_pkg::SS_IDLE);
      flag(sckOut, spi_core_pkg::SCK_IDLE);
      enable = 1'h1;
      idle(3);
      flag(sckOe, 1'h1);
      flag(ssOe, 1'h1);
      flag(sdoOe, 1'h0);
      sdoPinDirection = spi_core_pkg::DIR_OUTPUT;
      idle(3);
      flag(sdoOe, 1'h1);
      $display("test enable pins: done");
      pulse(RD);
      check(rxData, 8'h00);
      idle(4);
      flag(receiveReadError, 1'h1);
      pulse(CLRRE);
      idle(1);
      flag(receiveReadError, 1'h0);
      pulse(WR, 8'h11);
      pulse(WR, 8'h22);
      pulse(WR, 8'h33);
      idle(1);
      flag(transmitBufferEmpty, 1'h0);
      flag(transmitWriteError, 1'h1);
      pulse(CLRWE);
      idle(1);
      flag(transmitWriteError, 1'h0);
      transferCount = 11'h002; // loaded on the LOAD strobe, idle or busy
      pulse(LOAD);
      idle(4);
      flag(busy, 1'h1);
      i_master.frame(8'h5A, 8, 1'h0, miso);
      check(miso, 8'h11);
      idle(10);
      flag(busy, 1'h1);
      i_master.frame(8'hC3, 8, 1'h0, miso);
      check(miso, 8'h22);
      idle(10);
      flag(busy, 1'h0);
      flag(counterZeroFlag, 1'h1); // completion seen by flag, not counter
      flag(receiveBufferFull, 1'h1);
      flag(transmitBufferEmpty, 1'h1);
      pulse(RD);
      check(rxData, 8'h5A);
      pulse(RD);
      check(rxData, 8'hC3);
      idle(1);
      flag(receiveBufferFull, 1'h0);
      flag(receiveReadError, 1'h0);
      pulse(CLRCZ);
      $display("test queues and transfer: done");
      transferCount = 11'h001;
      pulse(LOAD);
      pulse(WR, 8'h77);
      idle(4);
      i_master.frame(8'h99, 8, 1'h0, miso);
      idle(10);
      pulse(WR, 8'h44);
      pulse(CLRBUF); // busy is low here
      idle(2);
      flag(transmitBufferEmpty, 1'h1);
      pulse(RD);
      check(rxData, 8'h00);
      pulse(CLRRE);
      pulse(CLRCZ);
      $display("test clear buffers: done");
      for (int w = 0; w < 8; w++) begin
         enable = 1'h0; // reconfigure only while disabled
         idle(2);
         lowBitFirst = w[0];
         transferWidth = w[2:0];
         enable = 1'h1;
         idle(3);
         n = (w == 0) ? 8 : w;
         m = (8'h01 << n) - 8'h01;
         w8 = 8'hB6 ^ w[7:0];
         pulse(LOAD);
         pulse(WR, w8);
         idle(4);
         i_master.frame(8'h6D, n, w[0], miso);
         idle(10);
         check(miso & m, w8 & m);
         pulse(RD);
         check(rxData & m, 8'h6D & m);
         flag(busy, 1'h0);
         pulse(CLRCZ);
      end
      $display("test width and order: done");
      transferCount = 11'h003;
      pulse(LOAD);
      pulse(WR, 8'hAA);
      pulse(WR, 8'h55);
      pulse(WR, 8'h3C);
      idle(4);
      i_master.frame(8'h0F, 7, 1'h1, miso);
      idle(10);
      flag(busy, 1'h1);
      flag(transmitBufferEmpty, 1'h0);
      enable = 1'h0;
      idle(3);
      flag(busy, 1'h0);
      flag(transmitBufferEmpty, 1'h1);
      flag(sdoOe, 1'h0);
      flag(sckOe, 1'h0);
      flag(counterZeroFlag, 1'h0);
      enable = 1'h1;
      idle(3);
      pulse(RD);
      check(rxData, 8'h00);
      idle(1);
      flag(receiveReadError, 1'h1);
      $display("test disable abort: done");
      report_and_stop();
   end
endmodule : spi_enable_busy_fifo_core_tb
